// >>> rtl/nvac_core.sv
// Overview of operation
// - 1024 bytes, reachable only through registers.
// - Fetches and byte mode transfers move one byte; page writes and erases cover all tagged slots.
// - Control register at sector 1 offset 40H.
// - Ten bit address, high bits 7-2 zero.
// - Data register holds write or fetched byte.
// - Short timing: erase 3.2 ms, write 2.2 ms.
// - Long timing: erase 3.7 ms, write 3.0 ms.
// - Erase needs wipe enable; cleared after erase.
// - Wipe go starts erase only when enabled.
// - Mode bit selects page or byte operation.
// - Sixteen byte internal page buffer.
// - Write needs program enable; cleared after write.
// - Program go starts write only when enabled.
// - Reads only while fetch enable is set.
// - Fetch go starts read only when enabled.
// - Page mode increments low nibble, stops 0FH.
// - Erased page bytes read back as zero.
// - Fetched byte stays until next operation.
`timescale 1ns/100ps
`include "nvac_defines.svh"

module nvac_core
  import nvac_pkg::*;
#(
  parameter int SUB_HZ = 32768,
  parameter int DEPTH = 1024,
  parameter int PAGE = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire nvac_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic sub_clk,
  output logic nvm_done
);

  // Address and page index widths follow the array and page sizes.
  localparam int AW = $clog2(DEPTH);
  localparam int PW = $clog2(PAGE);

  // Converts a duration in microseconds to whole sub clock ticks, rounded up.
  function automatic logic [15:0] us_to_ticks(input int us);
    longint t;
    t = (longint'(us) * longint'(SUB_HZ) + 64'h00000000000F423F) / 64'h00000000000F4240;
    if (t < 1) begin
      t = 1;
    end
    return t[15:0];
  endfunction

  // Page mode address step: only the low nibble moves and it saturates at the boundary.
  function automatic logic [AW-1:0] page_step(input logic [AW-1:0] a);
    logic [AW-1:0] r;
    r = a;
    if (a[PW-1:0] != {PW{1'b1}}) begin
      r[PW-1:0] = a[PW-1:0] + {{(PW-1){1'b0}}, 1'b1};
    end
    return r;
  endfunction

  // True for an access to the control register; read and write paths share it.
  function automatic logic hits_ctrl(input nvac_sfr_req_t r);
    return r.sector == `NVAC_CTRL_SECTOR && r.addr == `NVAC_CTRL_OFS;
  endfunction

  // True for an access to the directly reached sector.
  function automatic logic hits_direct(input nvac_sfr_req_t r);
    return r.sector == `NVAC_DIRECT_SECTOR;
  endfunction

  // A go bit takes only if its enable was set by an earlier write, not by the same one.
  function automatic logic go_taken(input logic go, input logic en_before);
    return go & en_before;
  endfunction

  // Tick counts are fixed at build time; another sub clock rate needs SUB_HZ set to match.
  localparam logic [15:0] WIPE_SHORT = us_to_ticks(`NVAC_WIPE_US_SHORT);
  localparam logic [15:0] PROG_SHORT = us_to_ticks(`NVAC_PROG_US_SHORT);
  localparam logic [15:0] WIPE_LONG = us_to_ticks(`NVAC_WIPE_US_LONG);
  localparam logic [15:0] PROG_LONG = us_to_ticks(`NVAC_PROG_US_LONG);

  // The array is private; no CPU address space reaches it.
  logic [7:0] mem [DEPTH];

  // Controller registers with their next values, then the sub clock sampling flops and helper signals.
  nvac_state_t state_q, state_d;
  nvac_ctrl_t ctrl_q, ctrl_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] byte_q, byte_d;
  logic [7:0] buf_q [PAGE];
  logic [7:0] buf_d [PAGE];
  logic [PAGE-1:0] tag_q, tag_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic sub_s1_q, sub_s2_q, sub_s3_q;
  logic sub_tick;
  logic [15:0] target;
  logic commit_wipe, commit_prog;
  logic [AW-1:0] page_base;
  nvac_ctrl_t wr_ctrl;

  // The sub clock is sampled through two flops; the second and a third, delayed copy feed the edge detector.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      sub_s1_q <= sub_clk;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  // A false tick just after reset is harmless; the count is cleared as each cycle starts.
  assign sub_tick = sub_s2_q & ~sub_s3_q;
  assign wr_ctrl = nvac_ctrl_t'(sfr_req.wdata);
  assign page_base = {addr_q[AW-1:PW], {PW{1'b0}}};

  // Duration depends on the cycle type and the timing select, fixed while a cycle runs.
  always_comb begin
    if (state_q == NVAC_WIPE) begin
      target = ctrl_q.timing_sel ? WIPE_LONG : WIPE_SHORT;
    end else begin
      target = ctrl_q.timing_sel ? PROG_LONG : PROG_SHORT;
    end
  end

  // Next state of the whole controller; register writes are ignored while a cycle runs,
  // which keeps the address and buffer stable for the cell operation in flight.
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    byte_d = byte_q;
    buf_d = buf_q;
    tag_d = tag_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    commit_wipe = 1'b0;
    commit_prog = 1'b0;
    // Register read path; unmapped offsets answer zero.
    // Reads are served in every state, so software can poll the go bits while busy.
    if (sfr_req.rd) begin
      rdata_d = 8'h00;
      if (hits_ctrl(sfr_req)) begin
        rdata_d = ctrl_q;
      end else if (hits_direct(sfr_req)) begin
        case (sfr_req.addr)
          `NVAC_ADDR_LOW_OFS: rdata_d = addr_q[7:0];
          `NVAC_ADDR_HIGH_OFS: rdata_d = {6'h00, addr_q[AW-1:8]};
          `NVAC_BYTE_PORT_OFS: rdata_d = byte_q;
          default: rdata_d = 8'h00;
        endcase
      end
    end
    case (state_q)
      NVAC_IDLE: begin
        if (sfr_req.wr && hits_direct(sfr_req)) begin
          case (sfr_req.addr)
            `NVAC_ADDR_LOW_OFS: addr_d[7:0] = sfr_req.wdata;
            `NVAC_ADDR_HIGH_OFS: addr_d[AW-1:8] = sfr_req.wdata[1:0];
            `NVAC_BYTE_PORT_OFS: begin
              byte_d = sfr_req.wdata;
              if (ctrl_q.page_mode) begin
                // Each data write tags one page slot, then steps the address.
                buf_d[addr_q[PW-1:0]] = sfr_req.wdata;
                tag_d[addr_q[PW-1:0]] = 1'b1;
                addr_d = page_step(addr_q);
              end
            end
            default: begin
            end
          endcase
        end
        if (sfr_req.wr && hits_ctrl(sfr_req)) begin
          ctrl_d.timing_sel = wr_ctrl.timing_sel;
          ctrl_d.page_mode = wr_ctrl.page_mode;
          ctrl_d.wipe_enable = wr_ctrl.wipe_enable;
          ctrl_d.program_enable = wr_ctrl.program_enable;
          ctrl_d.fetch_enable = wr_ctrl.fetch_enable;
          // A go bit takes only if its enable was already set before this write.
          ctrl_d.wipe_go = go_taken(wr_ctrl.wipe_go, ctrl_q.wipe_enable);
          ctrl_d.program_go = go_taken(wr_ctrl.program_go, ctrl_q.program_enable);
          ctrl_d.fetch_go = go_taken(wr_ctrl.fetch_go, ctrl_q.fetch_enable);
          if (ctrl_q.wipe_enable && !wr_ctrl.wipe_enable) begin
            tag_d = '0; // Dropping the wipe enable empties the page buffer.
          end
          // The count restarts on every control write taken in idle, so no cycle inherits old ticks.
          cnt_d = 16'h0000;
          if (ctrl_d.wipe_go) begin
            state_d = NVAC_WIPE;
          end else if (ctrl_d.program_go) begin
            state_d = NVAC_PROG;
          end else if (ctrl_d.fetch_go) begin
            state_d = NVAC_FETCH;
          end
        end
      end
      NVAC_FETCH: begin
        // A fetch is not timed; the array answers within one system clock.
        // The byte stays in the data register until the next operation.
        byte_d = mem[addr_q];
        ctrl_d.fetch_go = 1'b0;
        if (ctrl_q.page_mode) begin
          addr_d = page_step(addr_q);
        end
        state_d = NVAC_IDLE;
      end
      NVAC_WIPE, NVAC_PROG: begin
        if (sub_tick) begin
          cnt_d = cnt_q + 16'h0001;
        end
        // The count is compared before it moves, so a cycle lasts at least the full tick count.
        if (cnt_q >= target) begin
          if (state_q == NVAC_WIPE) begin
            commit_wipe = 1'b1;
            ctrl_d.wipe_go = 1'b0;
            ctrl_d.wipe_enable = 1'b0;
          end else begin
            commit_prog = 1'b1;
            ctrl_d.program_go = 1'b0;
            ctrl_d.program_enable = 1'b0;
          end
          tag_d = '0;
          done_d = 1'b1;
          state_d = NVAC_IDLE;
        end
      end
      default: begin
        state_d = NVAC_IDLE;
      end
    endcase
  end

  // Control and data registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= NVAC_IDLE;
      ctrl_q <= nvac_ctrl_t'(`NVAC_CTRL_RST);
      addr_q <= `NVAC_ADDR_RST;
      byte_q <= `NVAC_BYTE_RST;
      tag_q <= '0;
      cnt_q <= 16'h0000;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      byte_q <= byte_d;
      tag_q <= tag_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // Page buffer data needs no reset; the tags alone decide which slots are used.
  always_ff @(posedge sys_clk) begin
    buf_q <= buf_d;
  end

  // Cell array update at the end of a timed cycle; a byte write overwrites in place,
  // which stands in for the automatic erase that precedes it.
  // In page mode only tagged slots change, so a partly filled page leaves its other bytes alone.
  always_ff @(posedge sys_clk) begin
    if (commit_wipe) begin
      if (ctrl_q.page_mode) begin
        for (int i = 0; i < PAGE; i++) begin
          if (tag_q[i]) begin
            mem[page_base | AW'(i)] <= 8'h00;
          end
        end
      end else begin
        mem[addr_q] <= 8'h00;
      end
    end else if (commit_prog) begin
      if (ctrl_q.page_mode) begin
        for (int i = 0; i < PAGE; i++) begin
          if (tag_q[i]) begin
            mem[page_base | AW'(i)] <= buf_q[i];
          end
        end
      end else begin
        mem[addr_q] <= byte_q;
      end
    end
  end

  // Both outputs come straight from flip-flops.
  assign sfr_rdata = rdata_q;
  assign nvm_done = done_q;

endmodule // nvac_core

// >>> shared/nvac_defines.svh
`ifndef NVAC_DEFINES_SVH
`define NVAC_DEFINES_SVH

// Register offsets; the control register sits in sector 1, the others in sector 0.
`define NVAC_CTRL_OFS 8'h40
`define NVAC_ADDR_LOW_OFS 8'h48
`define NVAC_ADDR_HIGH_OFS 8'h49
`define NVAC_BYTE_PORT_OFS 8'h4A
`define NVAC_CTRL_SECTOR 1'h1
`define NVAC_DIRECT_SECTOR 1'h0

// Control register field positions.
`define NVAC_BIT_TIMING_SEL 7
`define NVAC_BIT_WIPE_EN 6
`define NVAC_BIT_WIPE_GO 5
`define NVAC_BIT_PAGE_MODE 4
`define NVAC_BIT_PROG_EN 3
`define NVAC_BIT_PROG_GO 2
`define NVAC_BIT_FETCH_EN 1
`define NVAC_BIT_FETCH_GO 0

// Reset values.
`define NVAC_CTRL_RST 8'h00
`define NVAC_BYTE_RST 8'h00
`define NVAC_ADDR_RST 10'h000

// Cycle durations in microseconds.
`define NVAC_WIPE_US_SHORT 3200
`define NVAC_PROG_US_SHORT 2200
`define NVAC_WIPE_US_LONG 3700
`define NVAC_PROG_US_LONG 3000

`endif

// >>> shared/nvac_pkg.sv
package nvac_pkg;

  // One special function register access from the CPU, already resolved to sector and offset.
  typedef struct packed {
    logic sector;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } nvac_sfr_req_t;

  // Control register layout, most significant field first.
  typedef struct packed {
    logic timing_sel;
    logic wipe_enable;
    logic wipe_go;
    logic page_mode;
    logic program_enable;
    logic program_go;
    logic fetch_enable;
    logic fetch_go;
  } nvac_ctrl_t;

  typedef enum logic [3:0] {
    NVAC_IDLE = 4'b0001,
    NVAC_FETCH = 4'b0010,
    NVAC_WIPE = 4'b0100,
    NVAC_PROG = 4'b1000
  } nvac_state_t;

endpackage

// >>> tb/nvac_core_assertions.sv
`timescale 1ns/100ps
module nvac_core_assertions
  import nvac_pkg::*;
#(parameter int SUB_HZ = 32768, parameter int DEPTH = 1024, parameter int PAGE = 16) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire nvac_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sub_clk,
  input wire logic nvm_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rc;
  logic rq;
  // Control reads, and reads of the direct sector.
  assign rc = sfr_req.rd && sfr_req.sector && sfr_req.addr == 8'h40;
  assign rq = sfr_req.rd && !sfr_req.sector;
  property p_done_pulse; nvm_done |=> !nvm_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_hold; !sfr_req.rd |=> $stable(sfr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_high; rq && sfr_req.addr == 8'h49 |=> sfr_rdata[7:2] == 6'h00; endproperty
  a_high: assert property (p_high) else $error("high address bits");
  property p_s1; sfr_req.rd && sfr_req.sector && sfr_req.addr != 8'h40 |=> !sfr_rdata; endproperty
  a_s1: assert property (p_s1) else $error("sector 1 hole");
  property p_s0; rq && (sfr_req.addr < 8'h48 || sfr_req.addr > 8'h4A) |=> !sfr_rdata; endproperty
  a_s0: assert property (p_s0) else $error("sector 0 hole");
  property p_go_clear; rc && nvm_done |=> !sfr_rdata[5] && !sfr_rdata[2]; endproperty
  a_go_clear: assert property (p_go_clear) else $error("go bit left set");
  // A fetch lasts one cycle, so the control read right after one that shows it sees it low.
  property p_fetch; rc ##1 (rc && sfr_rdata[0]) |=> !sfr_rdata[0]; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch stuck");
  // The sub clock is still high a few cycles after the rise that ends a cycle.
  property p_sub; nvm_done |-> $past(sub_clk, 3); endproperty
  a_sub: assert property (p_sub) else $error("done off sub clock");
  c_done: cover property (rc && nvm_done);
  c_fetch: cover property (rc ##1 (rc && sfr_rdata[0]));
  c_high: cover property (rq && sfr_req.addr == 8'h49);
endmodule // nvac_core_assertions

bind nvac_core nvac_core_assertions #(.SUB_HZ(SUB_HZ), .DEPTH(DEPTH), .PAGE(PAGE)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .sub_clk(sub_clk), .nvm_done(nvm_done));

// >>> tb/nvac_core_test.sv
`timescale 1ns/100ps
`include "nvac_defines.svh"
module nvac_core_test
  import nvac_pkg::*;
;
  localparam int SUBHZ = 10000;
  localparam logic [7:0] C = `NVAC_CTRL_OFS;
  localparam logic [7:0] AL = `NVAC_ADDR_LOW_OFS;
  localparam logic [7:0] AH = `NVAC_ADDR_HIGH_OFS;
  localparam logic [7:0] BP = `NVAC_BYTE_PORT_OFS;
  logic sys_clk;
  logic rst_n;
  logic sub_clk;
  logic nvm_done;
  logic [7:0] sfr_rdata;
  nvac_sfr_req_t sfr_req;
  int errors = 0;
  int n_compared = 0;

  nvac_core #(.SUB_HZ(SUBHZ)) i_nvac_core (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .sub_clk(sub_clk),
    .nvm_done(nvm_done)
  );

  // System clock, and a sub clock of 20 cycles that runs from the start, before any cycle.
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = !sys_clk;
  end
  initial begin
    sub_clk = 1'h0;
    #36;
    forever #100 sub_clk = !sub_clk;
  end

  // Sub clock ticks for a duration; rounded up so a cycle is never short.
  function automatic int tk(input int us);
    return (us * SUBHZ + 999999) / 1000000;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, g, e);
    end
  endtask
  // An access is set up just after an edge and taken at the next one.
  task automatic acc(input logic s, input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr_req = '{s, a, w, !w, d};
  endtask
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    acc(s, a, 1'h1, d);
  endtask
  task automatic rdv(input logic s, input logic [7:0] a, output logic [7:0] v);
    acc(s, a, 1'h0, 8'h00);
    @(posedge sys_clk);
    #1 sfr_req = '0;
    v = sfr_rdata;
  endtask
  task automatic seta(input logic [9:0] a);
    wr(1'h0, AL, a[7:0]);
    wr(1'h0, AH, {6'h00, a[9:8]});
  endtask
  // Enable then go, then poll control every cycle until all go bits drop, counting done pulses.
  task automatic op(input logic [7:0] en, input logic [7:0] go, input int t);
    int n;
    int nd;
    logic [7:0] v;
    n = 0;
    nd = 0;
    wr(1'h1, C, en);
    wr(1'h1, C, en | go);
    acc(1'h1, C, 1'h0, 8'h00);
    do begin
      acc(1'h1, C, 1'h0, 8'h00);
      n++;
      if (nvm_done !== 1'h0) begin
        nd++;
      end
    end while ((sfr_rdata & 8'h25) != 8'h00 && n < 2000);
    rdv(1'h1, C, v);
    chk(v, en & 8'h92);
    chk(8'(nd), (t > 0) ? 8'h01 : 8'h00);
    if (t > 0) begin
      chk({7'h00, n >= (t - 1) * 20 && n <= t * 20 + 12}, 8'h01);
    end
  endtask
  task automatic bread(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] v;
    seta(a);
    op(8'h02, 8'h01, 0);
    rdv(1'h0, BP, v);
    chk(v, e);
  endtask
  task automatic stop_test;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The run needs some 5000 cycles; a hang is cut at ten times that.
  initial begin
    #500000;
    errors++;
    stop_test;
  end

  initial begin
    logic [7:0] v;
    logic [7:0] d;
    logic [7:0] d2;
    logic [9:0] a;
    logic [8:0] ra [6];
    ra = '{{1'h1, C}, {1'h0, AL}, {1'h0, AH}, {1'h0, BP}, 9'h047, 9'h141};
    rst_n = 1'h0;
    sfr_req = '0;
    void'($urandom(12752));
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'h1;
    foreach (ra[i]) begin
      rdv(ra[i][8], ra[i][7:0], v);
      chk(v, 8'h00);
    end
    wr(1'h0, AH, 8'hFF);
    rdv(1'h0, AH, v);
    chk(v, 8'h03);
    wr(1'h1, C, 8'h01);
    wr(1'h1, C, 8'h04);
    wr(1'h1, C, 8'h20);
    rdv(1'h1, C, v);
    chk(v, 8'h00);
    $display("register test done");
    // Byte writes in both timings, the last two each followed by a byte erase.
    for (int i = 0; i < 4; i++) begin
      a = 10'($urandom);
      d = 8'($urandom);
      seta(a);
      wr(1'h0, BP, d);
      op({i[0], 7'h08}, 8'h04, tk(i[0] ? `NVAC_PROG_US_LONG : `NVAC_PROG_US_SHORT));
      bread(a, d);
      if (i[1]) begin
        op({i[0], 7'h40}, 8'h20, tk(i[0] ? `NVAC_WIPE_US_LONG : `NVAC_WIPE_US_SHORT));
        bread(a, 8'h00);
      end
    end
    wr(1'h1, C, 8'h00);
    wr(1'h0, BP, d);
    wr(1'h1, C, 8'h01);
    rdv(1'h0, BP, v);
    chk(v, d);
    $display("byte test done");
    // Page write near the top of a page; the low nibble must stop at F.
    a = {6'($urandom), 4'hE};
    d = 8'($urandom);
    d2 = 8'($urandom);
    wr(1'h1, C, 8'h10);
    seta(a);
    wr(1'h0, BP, d);
    wr(1'h0, BP, 8'($urandom));
    wr(1'h0, BP, d2);
    rdv(1'h0, AL, v);
    chk(v, {a[7:4], 4'hF});
    op(8'h18, 8'h04, tk(`NVAC_PROG_US_SHORT));
    seta(a);
    for (int k = 0; k < 3; k++) begin
      op(8'h12, 8'h01, 0);
      rdv(1'h0, BP, v);
      chk(v, k == 0 ? d : d2);
    end
    rdv(1'h0, AH, v);
    chk(v, {6'h00, a[9:8]});
    wr(1'h1, C, 8'h10);
    seta(a);
    wr(1'h0, BP, 8'h00);
    wr(1'h0, BP, 8'h00);
    op(8'h50, 8'h20, tk(`NVAC_WIPE_US_SHORT));
    bread(a, 8'h00);
    bread(a + 10'h001, 8'h00);
    $display("page test done");
    stop_test;
  end
endmodule // nvac_core_test
